/* uar_pkg.sv */
package uar_pkg;
  // ----------------------------------------------------------------------
  // Register indices on the plain register port
  // ----------------------------------------------------------------------
  localparam logic [2:0] UAR_ADDR_DATA   = 3'h0;  // Receive data, pops FIFO
  localparam logic [2:0] UAR_ADDR_STCTRL = 3'h1;  // Status and control
  localparam logic [2:0] UAR_ADDR_DIVLO  = 3'h2;  // Divisor low half
  localparam logic [2:0] UAR_ADDR_DIVHI  = 3'h3;  // Divisor high half
  localparam logic [2:0] UAR_ADDR_IRQ    = 3'h4;  // Interrupt enables
  // Status/control bit positions
  localparam int UAR_B_OVR   = 1;  // Overrun flag (ro)
  localparam int UAR_B_FRAMING_ERROR_FLAG  = 2;  // Framing error of oldest (ro)
  localparam int UAR_B_NINTH = 0;  // Ninth bit of oldest (ro)
  localparam int UAR_B_ADDR_DETECT_ENABLE = 3;  // Address detect enable
  localparam int UAR_B_RXEN  = 4;  // Receive enable
  localparam int UAR_B_NINE  = 6;  // Nine-bit receive select
  localparam int UAR_B_PORT  = 7;  // Port enable
  localparam int UAR_B_SYNC  = 5;  // Synchronous select (must be 0)
  localparam int UAR_B_PEND  = 0;  // Pending flag in irq register
  localparam int UAR_B_RIE   = 1;  // Receive irq enable
  localparam int UAR_B_PIE   = 2;  // Peripheral irq enable
  localparam int UAR_B_GIE   = 3;  // Global irq enable
  localparam int UAR_B_WIDE  = 4;  // Wide divisor select
  localparam int UAR_B_HIGH  = 5;  // High rate select
  // Oversampling and timing
  localparam int          UAR_OVS      = 16;     // Samples per bit
  localparam logic [3:0]  UAR_OVS_LAST = 4'hf;   // Last sample of a bit
  localparam logic [3:0]  UAR_HALF     = 4'h7;   // Half bit, start centre
  localparam logic [3:0]  UAR_MAJ_A    = 4'h6;   // Majority sample points
  localparam logic [3:0]  UAR_MAJ_B    = 4'h7;
  localparam logic [3:0]  UAR_MAJ_C    = 4'h8;
  localparam logic [3:0]  UAR_BITS8    = 4'h8;   // Data bits, 8-bit mode
  localparam logic [3:0]  UAR_BITS9    = 4'h9;   // Data bits, 9-bit mode
  localparam logic [1:0]  UAR_SLOW_DIV = 2'h3;   // Extra /4 when not high
  localparam logic [15:0] UAR_DIV_RST  = 16'h0000;
  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {UAR_IDLE, UAR_START, UAR_DATA, UAR_STOP}
    uar_state_t;
  typedef struct packed {
    logic       framing_error_flag;   // Framing error
    logic       ninth;  // Ninth data bit
    logic [7:0] data;   // Low data bits
  } uar_entry_t;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } uar_req_t;
endpackage

/* uar_rx.sv */
`timescale 1ns/100ps
// Function
// - Sample line sixteen times per bit
// - Completed characters enter two-entry FIFO
// - Run only when enabled, async, port on
// - Recheck start at half bit, else abandon
// - Majority vote each data bit centre
// - Low stop sample marks framing error
// - Push character, raise pending after stop
// - Pending while enabled and FIFO nonempty
// - Interrupt needs pending and three enables
// - Data read returns and pops oldest
// - Framing error per entry, oldest shown
// - Port off clears FIFO, overrun and framing error
// - Third character sets overrun, blocks reception
// - Overrun cleared by receive or port disable
// - Nine-bit mode shifts nine, shows ninth
// - Address detect keeps only ninth-set characters in nine-bit mode
// - LSB first, low start, high stop
// - Eight-bit divisor default, sixteen when wide
// - Divisor write restarts bit-rate timer
module uar_rx
  import uar_pkg::*;
#(
  parameter int DEPTH = 2  // Receive FIFO entries
) (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       serial_in_pin,  // Receive line, idles high
  input  wire uar_req_t   req,            // Register request
  output logic      [7:0] rdata,          // Read data, cycle after read
  output logic            rx_irq          // Receive interrupt request
);
  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  logic        port_enable, next_port_enable;       // Port on
  logic        rx_enable, next_rx_enable;           // Receiver on
  logic        sync_sel, next_sync_sel;             // Sync select
  logic        nine_bit_rx_select, next_nine;       // Nine-bit mode
  logic        addr_detect_enable, next_addr_detect_enable;      // Address filter
  logic        rx_irq_enable, next_rie;             // Irq enables
  logic        periph_irq_enable, next_pie;
  logic        global_irq_enable, next_gie;
  logic        wide_divisor_select, next_wide;
  logic        high_rate_select, next_high;
  logic [7:0]  baud_divisor_low, next_divlo;
  logic [7:0]  baud_divisor_high, next_divhi;
  logic [7:0]  next_rdata;
  logic        next_rx_irq;
  // ----------------------------------------------------------------------
  // Receiver state
  // ----------------------------------------------------------------------
  uar_state_t  state, next_state;          // Bit recovery phase
  logic [15:0] bit_rate_timer, next_brt;   // Divisor counter
  logic [1:0]  prescale, next_prescale;    // Extra /4 in low rate
  logic [3:0]  sub, next_sub;              // Oversample phase
  logic [3:0]  nbits, next_nbits;          // Data bits taken
  logic [8:0]  receive_shift_reg, next_rsr;
  logic [2:0]  votes, next_votes;          // Majority samples
  logic        line_q, next_line_q;        // Previous line level
  logic        overrun_flag, next_ovr;
  uar_entry_t  fifo [DEPTH];               // Character store
  uar_entry_t  next_fifo [DEPTH];
  logic [1:0]  count, next_count;          // Entries held
  logic        active, tick, vote, pop, push;
  logic [15:0] divisor;
  uar_entry_t  fresh;
  // Majority of three samples
  function automatic logic maj3(input logic [2:0] v);
    return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction
  // ----------------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------------
  // Writes, reads and the interrupt gate
  always_comb begin
    next_port_enable = port_enable;
    next_rx_enable   = rx_enable;
    next_sync_sel    = sync_sel;
    next_nine        = nine_bit_rx_select;
    next_addr_detect_enable       = addr_detect_enable;
    next_rie         = rx_irq_enable;
    next_pie         = periph_irq_enable;
    next_gie         = global_irq_enable;
    next_wide        = wide_divisor_select;
    next_high        = high_rate_select;
    next_divlo       = baud_divisor_low;
    next_divhi       = baud_divisor_high;
    next_rdata       = 8'h00;
    if (req.wr) begin
      unique case (req.addr)
        UAR_ADDR_STCTRL: begin
          next_port_enable = req.wdata[UAR_B_PORT];
          next_rx_enable   = req.wdata[UAR_B_RXEN];
          next_sync_sel    = req.wdata[UAR_B_SYNC];
          next_nine        = req.wdata[UAR_B_NINE];
          next_addr_detect_enable       = req.wdata[UAR_B_ADDR_DETECT_ENABLE];
        end
        UAR_ADDR_DIVLO: next_divlo = req.wdata;
        UAR_ADDR_DIVHI: next_divhi = req.wdata;
        UAR_ADDR_IRQ: begin
          // Pending bit is read-only, writes ignored
          next_rie  = req.wdata[UAR_B_RIE];
          next_pie  = req.wdata[UAR_B_PIE];
          next_gie  = req.wdata[UAR_B_GIE];
          next_wide = req.wdata[UAR_B_WIDE];
          next_high = req.wdata[UAR_B_HIGH];
        end
        default: ;
      endcase
    end
    if (req.rd) begin
      unique case (req.addr)
        // Oldest character
        UAR_ADDR_DATA: next_rdata = (count != 2'h0) ? fifo[0].data : 8'h00;
        UAR_ADDR_STCTRL: begin
          next_rdata[UAR_B_PORT]  = port_enable;
          next_rdata[UAR_B_RXEN]  = rx_enable;
          next_rdata[UAR_B_SYNC]  = sync_sel;
          next_rdata[UAR_B_NINE]  = nine_bit_rx_select;
          next_rdata[UAR_B_ADDR_DETECT_ENABLE] = addr_detect_enable;
          // Status of oldest unread entry
          next_rdata[UAR_B_FRAMING_ERROR_FLAG]  = (count != 2'h0) & fifo[0].framing_error_flag;
          next_rdata[UAR_B_NINTH] = (count != 2'h0) & fifo[0].ninth;
          next_rdata[UAR_B_OVR]   = overrun_flag;
        end
        UAR_ADDR_DIVLO: next_rdata = baud_divisor_low;
        UAR_ADDR_DIVHI: next_rdata = baud_divisor_high;
        UAR_ADDR_IRQ: begin
          next_rdata[UAR_B_PEND] = rx_enable & (count != 2'h0);
          next_rdata[UAR_B_RIE]  = rx_irq_enable;
          next_rdata[UAR_B_PIE]  = periph_irq_enable;
          next_rdata[UAR_B_GIE]  = global_irq_enable;
          next_rdata[UAR_B_WIDE] = wide_divisor_select;
          next_rdata[UAR_B_HIGH] = high_rate_select;
        end
        default: next_rdata = 8'h00;
      endcase
    end
    // Framing error alone never requests
    // Next enables used so the request never outlives a cleared gate
    next_rx_irq = next_rx_enable & (next_count != 2'h0) & next_rie &
                  next_pie & next_gie;
  end
  // Control registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      port_enable         <= 1'b0;
      rx_enable           <= 1'b0;
      sync_sel            <= 1'b0;
      nine_bit_rx_select  <= 1'b0;
      addr_detect_enable  <= 1'b0;
      rx_irq_enable       <= 1'b0;
      periph_irq_enable   <= 1'b0;
      global_irq_enable   <= 1'b0;
      wide_divisor_select <= 1'b0;
      high_rate_select    <= 1'b0;
      baud_divisor_low    <= 8'h00;
      baud_divisor_high   <= 8'h00;
      rdata               <= 8'h00;
      rx_irq              <= 1'b0;
    end else begin
      port_enable         <= next_port_enable;
      rx_enable           <= next_rx_enable;
      sync_sel            <= next_sync_sel;
      nine_bit_rx_select  <= next_nine;
      addr_detect_enable  <= next_addr_detect_enable;
      rx_irq_enable       <= next_rie;
      periph_irq_enable   <= next_pie;
      global_irq_enable   <= next_gie;
      wide_divisor_select <= next_wide;
      high_rate_select    <= next_high;
      baud_divisor_low    <= next_divlo;
      baud_divisor_high   <= next_divhi;
      rdata               <= next_rdata;
      rx_irq              <= next_rx_irq;
    end
  end
  // ----------------------------------------------------------------------
  // Bit recovery and FIFO
  // ----------------------------------------------------------------------
  // Sampling, shifting, pushing and popping
  always_comb begin
    active  = rx_enable & ~sync_sel & port_enable;
    // 8-bit divisor unless wide is selected
    divisor = wide_divisor_select ? {baud_divisor_high, baud_divisor_low}
                                  : {8'h00, baud_divisor_low};
    tick    = (bit_rate_timer == divisor) &
              (high_rate_select | (prescale == UAR_SLOW_DIV));
    next_brt      = bit_rate_timer;
    next_prescale = prescale;
    next_state    = state;
    next_sub      = sub;
    next_nbits    = nbits;
    next_rsr      = receive_shift_reg;
    next_votes    = votes;
    // Line history moves on ticks only, so an edge between ticks is kept
    next_line_q   = tick ? serial_in_pin : line_q;
    next_ovr      = overrun_flag;
    next_count    = count;
    next_fifo     = fifo;
    vote          = maj3(votes);
    push          = 1'b0;
    fresh         = '0;
    pop = req.rd & (req.addr == UAR_ADDR_DATA) & (count != 2'h0);
    // Timer restarts on divisor write
    if (req.wr & ((req.addr == UAR_ADDR_DIVLO) |
                  (req.addr == UAR_ADDR_DIVHI))) begin
      next_brt      = UAR_DIV_RST;
      next_prescale = 2'h0;
    end else if (bit_rate_timer == divisor) begin
      next_brt      = UAR_DIV_RST;
      next_prescale = prescale + 2'h1;
    end else begin
      next_brt = bit_rate_timer + 16'h0001;
    end
    // Sixteen oversample ticks per bit
    if (active & tick) begin
      unique case (state)
        UAR_IDLE: begin
          // Falling edge, low start bit expected
          if (line_q & ~serial_in_pin & ~overrun_flag) begin
            next_state = UAR_START;
            next_sub   = 4'h0;
          end
        end
        UAR_START: begin
          next_sub = sub + 4'h1;
          if (sub == UAR_HALF && serial_in_pin) begin
            // Abandon silently if line went back high
            next_state = UAR_IDLE;
          end else if (sub == UAR_OVS_LAST) begin
            // End of start bit, phase wraps to the first data bit
            next_state = UAR_DATA;
            next_nbits = 4'h0;
          end
        end
        UAR_DATA, UAR_STOP: begin
          next_sub = sub + 4'h1;
          if (sub == UAR_MAJ_A) next_votes[0] = serial_in_pin;
          if (sub == UAR_MAJ_B) next_votes[1] = serial_in_pin;
          if (sub == UAR_MAJ_C) next_votes[2] = serial_in_pin;
          if (sub == UAR_OVS_LAST) begin
            // Bit end reached at wrap, majority decided
            if (state == UAR_DATA) begin
              // LSB first into top of shifter
              if (nine_bit_rx_select)
                next_rsr = {vote, receive_shift_reg[8:1]};
              else
                next_rsr = {1'b0, vote, receive_shift_reg[7:1]};
              next_nbits = nbits + 4'h1;
              if (next_nbits == (nine_bit_rx_select ? UAR_BITS9
                                                    : UAR_BITS8))
                next_state = UAR_STOP;
            end else begin
              // Stop sample, low is framing error
              fresh.framing_error_flag  = ~vote;
              fresh.ninth = nine_bit_rx_select & receive_shift_reg[8];
              fresh.data  = receive_shift_reg[7:0];
              // Address filter
              push = ~(addr_detect_enable & nine_bit_rx_select &
                       ~fresh.ninth);
              next_state = UAR_IDLE;
            end
          end
        end
      endcase
    end
    if (pop) begin
      next_fifo[0] = fifo[1];
      next_count   = count - 2'h1;
    end
    if (push) begin
      // Full FIFO: overrun, stored characters kept
      if (count == 2'(DEPTH) && !pop) begin
        next_ovr = 1'b1;
      end else begin
        // Enter the two-entry FIFO, pending follows
        next_fifo[next_count[0]] = fresh;
        next_count = next_count + 2'h1;
      end
    end
    // Receive disable clears overrun
    if (!rx_enable) next_ovr = 1'b0;
    if (!rx_enable | sync_sel) next_state = UAR_IDLE;
    // Port off empties FIFO, clears overrun and idles, framing_error_flag included
    if (!port_enable) begin
      next_ovr   = 1'b0;
      next_count = 2'h0;
      next_state = UAR_IDLE;
    end
  end
  // Receiver registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state             <= UAR_IDLE;
      bit_rate_timer    <= UAR_DIV_RST;
      prescale          <= 2'h0;
      sub               <= 4'h0;
      nbits             <= 4'h0;
      receive_shift_reg <= 9'h000;
      votes             <= 3'h7;
      line_q            <= 1'b1;
      overrun_flag      <= 1'b0;
      count             <= 2'h0;
      for (int i = 0; i < DEPTH; i++) fifo[i] <= '0;
    end else begin
      state             <= next_state;
      bit_rate_timer    <= next_brt;
      prescale          <= next_prescale;
      sub               <= next_sub;
      nbits             <= next_nbits;
      receive_shift_reg <= next_rsr;
      votes             <= next_votes;
      line_q            <= next_line_q;
      overrun_flag      <= next_ovr;
      count             <= next_count;
      fifo              <= next_fifo;
    end
  end
  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_irq_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
    rx_irq |-> global_irq_enable && count != 2'h0)
    else $error("irq without enable or data");
  a_overrun_block: assert property (@(posedge ref_clk) disable iff (!rstn)
    overrun_flag && rx_enable && port_enable |=> $stable(count) || $fell(count) || count < $past(count))
    else $error("FIFO grew during overrun");
  a_count_bound: assert property (@(posedge ref_clk) disable iff (!rstn)
    count <= 2'(DEPTH))
    else $error("FIFO count past depth");
  a_port_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
    !port_enable |=> count == 2'h0 && !overrun_flag)
    else $error("port off did not clear");
  a_ovr_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
    !rx_enable |=> !overrun_flag)
    else $error("overrun survived disable");
  a_start_abort: assert property (@(posedge ref_clk) disable iff (!rstn)
    state == UAR_START && tick && active && sub == UAR_HALF &&
    serial_in_pin |=> state == UAR_IDLE)
    else $error("false start not abandoned");
  a_pop_read: assert property (@(posedge ref_clk) disable iff (!rstn)
    pop && !push && port_enable |=> count == $past(count) - 2'h1)
    else $error("read did not pop");
  a_idle_off: assert property (@(posedge ref_clk) disable iff (!rstn)
    !active |=> state == UAR_IDLE || $past(rx_enable && !sync_sel && port_enable))
    else $error("receiver ran while disabled");
  c_push: cover property (@(posedge ref_clk) push && count == 2'h0);
  c_full: cover property (@(posedge ref_clk) count == 2'(DEPTH));
  c_ovr:  cover property (@(posedge ref_clk) $rose(overrun_flag));
  c_framing_error_flag: cover property (@(posedge ref_clk) push && fresh.framing_error_flag);
endmodule

/* uar_tx_model.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Remote asynchronous transmitter on the receive line
// ----------------------------------------------------------------------
module uar_tx_model (
  input  wire logic ref_clk,        // System clock
  output logic      serial_in_pin   // Line towards the receiver
);
  // Line idles at mark level
  initial serial_in_pin = 1'b1;

  // One frame: start, data bits, stop, then one idle bit
  task automatic send(input logic [8:0] d, input int nb, input logic stp,
                      input int clks);
    @(posedge ref_clk);
    serial_in_pin <= 1'b0;          // Low start bit
    repeat (clks) @(posedge ref_clk);
    for (int i = 0; i < nb; i++) begin
      serial_in_pin <= d[i];        // Least significant first
      repeat (clks) @(posedge ref_clk);
    end
    serial_in_pin <= stp;           // High stop unless faulted
    repeat (clks) @(posedge ref_clk);
    serial_in_pin <= 1'b1;          // Back to idle
    repeat (clks) @(posedge ref_clk);
  endtask

  // Low pulse shorter than half a bit, then a quiet gap
  task automatic glitch(input int n);
    @(posedge ref_clk);
    serial_in_pin <= 1'b0;
    repeat (n) @(posedge ref_clk);
    serial_in_pin <= 1'b1;
    repeat (40) @(posedge ref_clk);
  endtask
endmodule

/* uart_async_receiver_bench.sv */
`timescale 1ns/100ps
module uart_async_receiver_bench
  import uar_pkg::*;
();
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  localparam int BIT = 32;        // Clocks per bit, divisor 1, high rate
  logic       ref_clk;            // System clock
  logic       rstn;               // Active-low reset
  logic       serial_in_pin;      // Receive line
  uar_req_t   req;                // Register request
  logic [7:0] rdata;              // Read data
  logic       rx_irq;             // Interrupt request
  int         num_errors;         // Mismatches
  int         total_checks;       // Comparisons

  // Clock, 4 ns period
  initial ref_clk = 1'b0;
  always #2 ref_clk = ~ref_clk;

  uar_rx uar_rx_inst (
    .ref_clk       (ref_clk),
    .rstn          (rstn),
    .serial_in_pin (serial_in_pin),
    .req           (req),
    .rdata         (rdata),
    .rx_irq        (rx_irq)
  );
  uar_tx_model uar_tx_model_inst (
    .ref_clk       (ref_clk),
    .serial_in_pin (serial_in_pin)
  );

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  // Compare and count
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One-cycle register write
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    req <= '0;
  endtask
  // One-cycle read, data taken in the following cycle
  task automatic rdc(input logic [2:0] a, input logic [7:0] exp,
                     input string what);
    @(posedge ref_clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    req <= '0;
    #1 check(what, rdata, exp);
  endtask
  // Interrupt level after writes have landed
  task automatic chk_irq(input logic exp);
    repeat (2) @(posedge ref_clk);
    #1 check("irq", {7'h00, rx_irq}, {7'h00, exp});
  endtask
  // Bounded wait for a character to arrive
  task automatic wait_irq();
    for (int i = 0; i < 4 * BIT && rx_irq !== 1'b1; i++) @(posedge ref_clk);
  endtask
  // Fixed gap for characters expected to be dropped
  task automatic settle();
    repeat (2 * BIT) @(posedge ref_clk);
  endtask
  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------------
  initial begin
    repeat (40000) @(posedge ref_clk);
    num_errors++;
    summarize();
  end

  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    req = '0;
    num_errors = 0;
    total_checks = 0;
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    rdc(UAR_ADDR_STCTRL, 8'h00, "status reset");
    rdc(3'h5, 8'h00, "unmapped");
    wr(UAR_ADDR_IRQ, 8'h2e);
    wr(UAR_ADDR_DIVHI, 8'h01);      // Ignored while divisor is narrow
    wr(UAR_ADDR_DIVLO, 8'h01);
    // Sync select keeps the receiver off
    wr(UAR_ADDR_STCTRL, 8'hb0);
    uar_tx_model_inst.send(9'h0a5, 8, 1'b1, BIT);
    settle();
    rdc(UAR_ADDR_IRQ, 8'h2e, "pend sync");
    // Plain character
    wr(UAR_ADDR_STCTRL, 8'h90);
    uar_tx_model_inst.send(9'h0a5, 8, 1'b1, BIT);
    wait_irq();
    chk_irq(1'b1);
    rdc(UAR_ADDR_IRQ, 8'h2f, "pend");
    rdc(UAR_ADDR_STCTRL, 8'h90, "status");
    rdc(UAR_ADDR_DATA, 8'ha5, "data");
    chk_irq(1'b0);
    // Framing error per entry, reception continues
    uar_tx_model_inst.send(9'h03c, 8, 1'b0, BIT);
    uar_tx_model_inst.send(9'h05a, 8, 1'b1, BIT);
    wait_irq();
    rdc(UAR_ADDR_STCTRL, 8'h94, "framing_error_flag");
    rdc(UAR_ADDR_DATA, 8'h3c, "data");
    rdc(UAR_ADDR_STCTRL, 8'h90, "framing_error_flag next");
    rdc(UAR_ADDR_DATA, 8'h5a, "data");
    // False start abandoned silently
    uar_tx_model_inst.glitch(4);
    uar_tx_model_inst.send(9'h081, 8, 1'b1, BIT);
    wait_irq();
    rdc(UAR_ADDR_DATA, 8'h81, "data");
    rdc(UAR_ADDR_DATA, 8'h00, "empty");
    // Overrun on the third character
    uar_tx_model_inst.send(9'h011, 8, 1'b1, BIT);
    uar_tx_model_inst.send(9'h022, 8, 1'b1, BIT);
    uar_tx_model_inst.send(9'h033, 8, 1'b1, BIT);
    settle();
    rdc(UAR_ADDR_STCTRL, 8'h92, "ovr");
    rdc(UAR_ADDR_DATA, 8'h11, "data");
    rdc(UAR_ADDR_DATA, 8'h22, "data");
    uar_tx_model_inst.send(9'h044, 8, 1'b1, BIT);
    settle();
    chk_irq(1'b0);
    rdc(UAR_ADDR_STCTRL, 8'h92, "ovr held");
    wr(UAR_ADDR_STCTRL, 8'h80);
    rdc(UAR_ADDR_STCTRL, 8'h80, "ovr clr");
    wr(UAR_ADDR_STCTRL, 8'h90);
    uar_tx_model_inst.send(9'h055, 8, 1'b1, BIT);
    wait_irq();
    // Interrupt gating
    wr(UAR_ADDR_IRQ, 8'h26);
    chk_irq(1'b0);
    rdc(UAR_ADDR_IRQ, 8'h27, "pend no gie");
    wr(UAR_ADDR_IRQ, 8'h2e);
    chk_irq(1'b1);
    rdc(UAR_ADDR_DATA, 8'h55, "data");
    wr(UAR_ADDR_IRQ, 8'h2f);                    // Pending bit is read-only
    chk_irq(1'b0);
    rdc(UAR_ADDR_IRQ, 8'h2e, "pend ro");
    // Nine-bit reception with address filter
    wr(UAR_ADDR_STCTRL, 8'hd8);
    uar_tx_model_inst.send(9'h012, 9, 1'b1, BIT);
    settle();
    rdc(UAR_ADDR_IRQ, 8'h2e, "filtered");
    uar_tx_model_inst.send(9'h1a7, 9, 1'b1, BIT);
    wait_irq();
    rdc(UAR_ADDR_STCTRL, 8'hd9, "ninth");
    rdc(UAR_ADDR_DATA, 8'ha7, "addr data");
    wr(UAR_ADDR_STCTRL, 8'hd0);
    uar_tx_model_inst.send(9'h0b3, 9, 1'b1, BIT);
    wait_irq();
    rdc(UAR_ADDR_STCTRL, 8'hd0, "ninth low");
    rdc(UAR_ADDR_DATA, 8'hb3, "data");
    // Receive off keeps framing_error_flag, port off clears all
    uar_tx_model_inst.send(9'h066, 9, 1'b0, BIT);
    wait_irq();
    rdc(UAR_ADDR_STCTRL, 8'hd4, "framing_error_flag nine");
    wr(UAR_ADDR_STCTRL, 8'hc0);
    rdc(UAR_ADDR_STCTRL, 8'hc4, "framing_error_flag rx off");
    rdc(UAR_ADDR_IRQ, 8'h2e, "pend rx off");
    wr(UAR_ADDR_STCTRL, 8'h00);
    rdc(UAR_ADDR_STCTRL, 8'h00, "port off");
    wr(UAR_ADDR_STCTRL, 8'hd0);
    rdc(UAR_ADDR_DATA, 8'h00, "flushed");
    // Low rate: tick every four clocks, 64 clocks a bit
    wr(UAR_ADDR_STCTRL, 8'h90);
    wr(UAR_ADDR_IRQ, 8'h0e);
    wr(UAR_ADDR_DIVLO, 8'h00);
    uar_tx_model_inst.send(9'h0c3, 8, 1'b1, 2 * BIT);
    wait_irq();
    rdc(UAR_ADDR_DATA, 8'hc3, "low rate");
    // Wide divisor, 32 clocks a bit
    wr(UAR_ADDR_IRQ, 8'h3e);
    wr(UAR_ADDR_DIVHI, 8'h00);
    wr(UAR_ADDR_DIVLO, 8'h01);
    uar_tx_model_inst.send(9'h03e, 8, 1'b1, BIT);
    wait_irq();
    rdc(UAR_ADDR_DATA, 8'h3e, "wide");
    summarize();
  end
endmodule
